// ===== hdl/cell_alert_pkg.sv
// Package with register map, field layout and carrier types of the alert block.
package cell_alert_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_CELLS  = 14;
    localparam int DATA_W     = 16;
    localparam int ADDR_W     = 8;
    localparam int INDEX_W    = 4;

    // ****************************************************************
    // Register indices
    // ****************************************************************
    localparam logic [7:0] ADDR_OVER_FLAGS   = 8'h08;
    localparam logic [7:0] ADDR_UNDER_FLAGS  = 8'h09;
    localparam logic [7:0] ADDR_EXTREME      = 8'h0A;
    localparam logic [7:0] ADDR_OVER_EN      = 8'h20;
    localparam logic [7:0] ADDR_UNDER_EN     = 8'h21;
    localparam logic [7:0] ADDR_CELL_EN      = 8'h22;
    localparam logic [7:0] ADDR_POLARITY     = 8'h23;
    localparam logic [7:0] ADDR_UNI_OVER_TH  = 8'h24;
    localparam logic [7:0] ADDR_BIP_OVER_TH  = 8'h25;
    localparam logic [7:0] ADDR_UNI_UNDER_TH = 8'h26;
    localparam logic [7:0] ADDR_BIP_UNDER_TH = 8'h27;
    localparam logic [7:0] ADDR_CONTROL      = 8'h28;
    localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h29;
    localparam logic [7:0] ADDR_IRQ_MASK     = 8'h2A;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int HIGH_IDX_LSB  = 8;
    localparam int LOW_IDX_LSB   = 0;
    localparam int CTRL_FILT_BIT = 0;
    localparam int CTRL_POL_BIT  = 1;
    localparam int IRQ_OVER_BIT  = 0;
    localparam int IRQ_UNDER_BIT = 1;
    localparam int IRQ_SCAN_BIT  = 2;
    localparam int IRQ_W         = 3;

    localparam logic [13:0] CELL_MASK_RESET = 14'h0000;
    localparam logic [15:0] THRESH_RESET    = 16'h0000;
    localparam logic [3:0]  INDEX_RESET     = 4'h0;
    localparam logic [3:0]  NO_RESULT       = 4'hF;
    localparam logic [2:0]  IRQ_RESET       = 3'h0;
    localparam logic [15:0] READ_ZERO       = 16'h0000;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef logic [DATA_W-1:0]                 cell_word_type;
    typedef cell_word_type [NUM_CELLS-1:0]     cell_set_type;

    typedef struct packed {
        logic         done;
        logic         scan;
        cell_set_type alu;
        cell_set_type iir;
    } acq_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_type;

endpackage : cell_alert_pkg

// ===== hdl/cell_alert_and_minmax_locator.sv
// Per-cell voltage alert flags and highest/lowest cell locator.
//
// Notes on behaviour
// - Over alert when cell above over threshold.
// - Polarity bit picks unipolar or bipolar over threshold.
// - Over alert only when its enable bit set.
// - Over alert held, re-judged at next acquisition.
// - Under alert when cell below under threshold.
// - Polarity bit picks unipolar or bipolar under threshold.
// - Under alert only when its enable bit set.
// - Under alert held, re-judged at next acquisition.
// - Over flags in bits 13:0, reset zero.
// - Under flags in bits 13:0, reset zero.
// - Report highest enabled cell as number 1..14.
// - Report lowest enabled cell as number 1..14.
// - Extremes update only on scan acquisitions.
// - Extremes use ALU or IIR data per filter select.
// - Search only unipolar or only bipolar cells.
// - No matching cell gives Fh in both fields.
// - Highest in 11:8, lowest in 3:0, reset zero.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module cell_alert_and_minmax_locator (
    input  wire logic                         sys_clk_i,
    input  wire logic                         sys_rst_i,
    input  wire logic                         clk_en_i,
    input  wire cell_alert_pkg::acq_type      acq_i,
    input  wire cell_alert_pkg::bus_req_type  bus_i,
    output var  logic [15:0]                  rd_data_o,
    output var  logic                         irq_o
);
    import cell_alert_pkg::*;

    // ****************************************************************
    // Overview
    // ****************************************************************
    // Each done pulse brings fourteen ALU and fourteen
    // IIR results, cell one in slot zero. Alerts use
    // the ALU set only; the search uses either set.
    //
    // The host sees a small register file. The three
    // status registers and the interrupt status are read
    // only; the rest is configuration that hardware never changes.
    //
    // Read data are registered: a read strobe shows
    // its word in the next cycle and zero otherwise.
    // Reads may follow each other with no gap.
    //
    // A low clock enable freezes every flop and so
    // ignores the bus and acquisition inputs. A done
    // pulse given then is lost; the producer must
    // repeat it once the enable returns.
    //
    // All arithmetic is combinational. Parallel
    // comparators were chosen over a sequential walk:
    // more area, but results are ready on the edge
    // that takes the acquisition.
    //
    // Configuration indices sit away from the status
    // registers, so a stray write to a status index
    // falls into the empty default branch.
    //
    // Interrupt status has three sticky bits: over
    // alert rose, under alert rose, scan updated the
    // extremes. Reading the status clears them. The
    // mask has the same layout, and the interrupt is
    // high while an unmasked bit is set.

    // ****************************************************************
    // State
    // ****************************************************************
    // All state is one packed struct. Read data and
    // interrupt are fields of it, so both outputs
    // come straight from flops.
    // Reset clears the extreme fields too, so they
    // read zero, not the no-result code, until the
    // first scan is judged.
    typedef struct packed {
        logic [NUM_CELLS-1:0] over_flags;
        logic [NUM_CELLS-1:0] under_flags;
        logic [INDEX_W-1:0]   high_idx;
        logic [INDEX_W-1:0]   low_idx;
        logic [NUM_CELLS-1:0] over_en;
        logic [NUM_CELLS-1:0] under_en;
        logic [NUM_CELLS-1:0] cell_en;
        logic [NUM_CELLS-1:0] polarity;
        logic [DATA_W-1:0]    uni_over_th;
        logic [DATA_W-1:0]    bip_over_th;
        logic [DATA_W-1:0]    uni_under_th;
        logic [DATA_W-1:0]    bip_under_th;
        logic                 filt_sel;
        logic                 search_pol;
        logic [IRQ_W-1:0]     irq_status;
        logic [IRQ_W-1:0]     irq_mask;
        logic [DATA_W-1:0]    rd_data;
        logic                 irq;
    } state_type;

    state_type state_reg;
    state_type state_next;

    localparam state_type STATE_RESET = '{
        over_flags:   CELL_MASK_RESET,
        under_flags:  CELL_MASK_RESET,
        high_idx:     INDEX_RESET,
        low_idx:      INDEX_RESET,
        over_en:      CELL_MASK_RESET,
        under_en:     CELL_MASK_RESET,
        cell_en:      CELL_MASK_RESET,
        polarity:     CELL_MASK_RESET,
        uni_over_th:  THRESH_RESET,
        bip_over_th:  THRESH_RESET,
        uni_under_th: THRESH_RESET,
        bip_under_th: THRESH_RESET,
        filt_sel:     1'b0,
        search_pol:   1'b0,
        irq_status:   IRQ_RESET,
        irq_mask:     IRQ_RESET,
        rd_data:      READ_ZERO,
        irq:          1'b0
    };

    // ****************************************************************
    // Per-cell threshold comparison
    // ****************************************************************
    // Bipolar cells carry two's complement results, so their
    // comparisons are signed; unipolar cells compare unsigned.
    // A cell exactly on its limit raises no alert.
    // The polarity bit picks both the threshold and
    // the number format, so one write moves a cell
    // between threshold pairs and compare modes.
    logic [NUM_CELLS-1:0] over_hit;
    logic [NUM_CELLS-1:0] under_hit;

    // One identical slice per cell. Slices share the
    // thresholds but read their own enable and
    // polarity bits, so cells never interact.
    genvar g;
    generate
        for (g = 0; g < NUM_CELLS; g++) begin : g_cell
            logic [DATA_W-1:0] v;
            logic              above;
            logic              below;
            assign v = acq_i.alu[g];
            assign above = state_reg.polarity[g]
                ? ($signed(v) > $signed(state_reg.bip_over_th))
                : (v > state_reg.uni_over_th);
            assign below = state_reg.polarity[g]
                ? ($signed(v) < $signed(state_reg.bip_under_th))
                : (v < state_reg.uni_under_th);
            assign over_hit[g]  = state_reg.over_en[g] & above;
            assign under_hit[g] = state_reg.under_en[g] & below;
        end
    endgenerate

    // ****************************************************************
    // Ordering helper
    // ****************************************************************
    // Shared by both searches. The signed mode comes
    // from the search polarity, since the search only
    // looks at cells of one polarity at a time.
    // The helper is pure and holds no state.
    function automatic logic is_greater(
        input logic [DATA_W-1:0] a,
        input logic [DATA_W-1:0] b,
        input logic              signed_mode
    );
        logic result;
        if (signed_mode) begin
            result = $signed(a) > $signed(b);
        end else begin
            result = a > b;
        end
        return result;
    endfunction : is_greater

    // ****************************************************************
    // Extreme cell search
    // ****************************************************************
    // The walk runs from cell one to fourteen and
    // replaces its result only on a strict gain, so
    // the first cell to reach a value keeps it.
    // This fourteen-stage chain is the longest path
    // of the block and sets its clock limit.
    // Disabled cells and cells of the other polarity
    // never enter the walk.
    logic [NUM_CELLS-1:0] cand;
    logic [INDEX_W-1:0]   high_found;
    logic [INDEX_W-1:0]   low_found;

    always_comb begin
        cell_set_type      src;
        logic [DATA_W-1:0] high_val;
        logic [DATA_W-1:0] low_val;
        logic              any;
        src      = acq_i.alu;
        high_val = READ_ZERO;
        low_val  = READ_ZERO;
        any      = 1'b0;
        // no candidate leaves both at Fh.
        high_found = NO_RESULT;
        low_found  = NO_RESULT;
        if (state_reg.filt_sel) begin
            src = acq_i.iir;
        end
        // only cells of the chosen polarity.
        cand = state_reg.cell_en
             & (state_reg.search_pol ? state_reg.polarity
                                     : ~state_reg.polarity);
        for (int i = 0; i < NUM_CELLS; i++) begin
            if (cand[i]) begin
                // strict compare keeps the lowest number on ties.
                if (!any || is_greater(src[i], high_val,
                                       state_reg.search_pol)) begin
                    high_val   = src[i];
                    // cell number is index plus one.
                    high_found = INDEX_W'(i + 1);
                end
                if (!any || is_greater(low_val, src[i],
                                       state_reg.search_pol)) begin
                    low_val   = src[i];
                    // cell number is index plus one.
                    low_found = INDEX_W'(i + 1);
                end
                any = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [IRQ_W-1:0] events;
        logic [IRQ_W-1:0] status;
        state_next = state_reg;
        events     = IRQ_RESET;
        status     = IRQ_RESET;

        // Flags are rebuilt at every done pulse: a set
        // flag holds until the next acquisition and is
        // cleared there only if its condition is gone.
        // Only a rising flag raises its event, so a
        // cell that stays in alert does not retrigger.
        if (acq_i.done) begin
            // re-judged each acquisition, cleared only if resolved.
            state_next.over_flags  = over_hit;
            // re-judged each acquisition, cleared only if resolved.
            state_next.under_flags = under_hit;
            events[IRQ_OVER_BIT]  = |(over_hit & ~state_reg.over_flags);
            events[IRQ_UNDER_BIT] = |(under_hit & ~state_reg.under_flags);
            // extremes move only on scan requests.
            if (acq_i.scan) begin
                state_next.high_idx = high_found;
                state_next.low_idx  = low_found;
                events[IRQ_SCAN_BIT] = 1'b1;
            end
        end

        // Writes land at the edge that takes them and
        // are seen by a read in the next cycle. A write
        // and a done pulse in one cycle touch disjoint
        // fields, so they never conflict.
        // Configuration writes; status registers have no write case.
        if (bus_i.wr) begin
            case (bus_i.addr)
                ADDR_OVER_EN:
                    state_next.over_en = bus_i.wdata[NUM_CELLS-1:0];
                ADDR_UNDER_EN:
                    state_next.under_en = bus_i.wdata[NUM_CELLS-1:0];
                ADDR_CELL_EN:
                    state_next.cell_en = bus_i.wdata[NUM_CELLS-1:0];
                ADDR_POLARITY:
                    state_next.polarity = bus_i.wdata[NUM_CELLS-1:0];
                ADDR_UNI_OVER_TH:  state_next.uni_over_th  = bus_i.wdata;
                ADDR_BIP_OVER_TH:  state_next.bip_over_th  = bus_i.wdata;
                ADDR_UNI_UNDER_TH: state_next.uni_under_th = bus_i.wdata;
                ADDR_BIP_UNDER_TH: state_next.bip_under_th = bus_i.wdata;
                ADDR_CONTROL: begin
                    state_next.filt_sel   = bus_i.wdata[CTRL_FILT_BIT];
                    state_next.search_pol = bus_i.wdata[CTRL_POL_BIT];
                end
                ADDR_IRQ_MASK:
                    state_next.irq_mask = bus_i.wdata[IRQ_W-1:0];
                default: ;
            endcase
        end

        // Only a read strobe selects a word; in any
        // other cycle the data return to zero, so no
        // stale word is ever shown.
        // Read data register; unmapped and unused bits read as zero.
        state_next.rd_data = READ_ZERO;
        status = state_reg.irq_status;
        if (bus_i.rd) begin
            case (bus_i.addr)
                // over flags in low 14 bits.
                ADDR_OVER_FLAGS:
                    state_next.rd_data = {2'h0, state_reg.over_flags};
                // under flags in low 14 bits.
                ADDR_UNDER_FLAGS:
                    state_next.rd_data = {2'h0, state_reg.under_flags};
                // highest in 11:8, lowest in 3:0.
                ADDR_EXTREME:
                    state_next.rd_data = {4'h0, state_reg.high_idx,
                                          4'h0, state_reg.low_idx};
                ADDR_OVER_EN:
                    state_next.rd_data = {2'h0, state_reg.over_en};
                ADDR_UNDER_EN:
                    state_next.rd_data = {2'h0, state_reg.under_en};
                ADDR_CELL_EN:
                    state_next.rd_data = {2'h0, state_reg.cell_en};
                ADDR_POLARITY:
                    state_next.rd_data = {2'h0, state_reg.polarity};
                ADDR_UNI_OVER_TH:  state_next.rd_data = state_reg.uni_over_th;
                ADDR_BIP_OVER_TH:  state_next.rd_data = state_reg.bip_over_th;
                ADDR_UNI_UNDER_TH:
                    state_next.rd_data = state_reg.uni_under_th;
                ADDR_BIP_UNDER_TH:
                    state_next.rd_data = state_reg.bip_under_th;
                ADDR_CONTROL:
                    state_next.rd_data = {14'h0000, state_reg.search_pol,
                                          state_reg.filt_sel};
                ADDR_IRQ_STATUS: begin
                    state_next.rd_data = {13'h0000, state_reg.irq_status};
                    status = IRQ_RESET;
                end
                ADDR_IRQ_MASK:
                    state_next.rd_data = {13'h0000, state_reg.irq_mask};
                default: state_next.rd_data = READ_ZERO;
            endcase
        end

        // Set and read clear may meet in one cycle; the
        // set wins, so no event is lost between reads.
        // A new event in the read cycle survives the read clear.
        state_next.irq_status = status | events;
        state_next.irq = |(state_next.irq_status & state_next.irq_mask);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // The reset clears all at once; its release must
    // meet recovery time, which the reset logic
    // upstream is expected to ensure.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= STATE_RESET;
        end else if (clk_en_i) begin
            state_reg <= state_next;
        end
    end

    // Both outputs are plain copies of flops. The
    // interrupt follows a mask write or a read clear
    // with no extra cycle of delay.
    assign rd_data_o = state_reg.rd_data;
    assign irq_o     = state_reg.irq;

endmodule : cell_alert_and_minmax_locator

`default_nettype wire

// ===== dv/cell_alert_chk.sv
// Checker on the read port and interrupt of the cell alert block.
`timescale 1ns/10ps
`default_nettype none
module cell_alert_chk (
    input  wire logic                        sys_clk_i,
    input  wire logic                        sys_rst_i,
    input  wire logic                        clk_en_i,
    input  wire cell_alert_pkg::acq_type     acq_i,
    input  wire cell_alert_pkg::bus_req_type bus_i,
    input  wire logic [15:0]                 rd_data_o,
    input  wire logic                        irq_o
);
    import cell_alert_pkg::*;
    logic rd_q_reg;
    logic ev_reg;

    // A frozen clock enable holds the read data, so the read marker holds too.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_q_reg <= 1'b0;
            ev_reg   <= 1'b0;
        end else begin
            ev_reg <= clk_en_i && (acq_i.done || bus_i.wr);
            if (clk_en_i) begin
                rd_q_reg <= bus_i.rd;
            end
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence read_of(logic [7:0] a);
        clk_en_i && bus_i.rd && bus_i.addr == a;
    endsequence

    a_over_upper_zero: assert property (
        read_of(ADDR_OVER_FLAGS) |=> rd_data_o[15:14] == 2'h0)
        else $error("over flag read shows upper bits");
    a_under_upper_zero: assert property (
        read_of(ADDR_UNDER_FLAGS) |=> rd_data_o[15:14] == 2'h0)
        else $error("under flag read shows upper bits");
    a_extreme_gaps_zero: assert property (
        read_of(ADDR_EXTREME) |=>
            rd_data_o[15:12] == 4'h0 && rd_data_o[7:4] == 4'h0)
        else $error("extreme read shows unused bits");
    a_extreme_none_both: assert property (
        read_of(ADDR_EXTREME) |=>
            (rd_data_o[11:8] == NO_RESULT) == (rd_data_o[3:0] == NO_RESULT))
        else $error("only one extreme field reports no result");
    a_extreme_zero_pair: assert property (
        read_of(ADDR_EXTREME) |=>
            (rd_data_o[11:8] == 4'h0) == (rd_data_o[3:0] == 4'h0))
        else $error("only one extreme field is zero");
    a_read_idle_zero: assert property (
        !rd_q_reg |-> rd_data_o == READ_ZERO)
        else $error("read data shown without a read");
    a_irq_has_cause: assert property (
        $rose(irq_o) |-> ev_reg || $past(ev_reg))
        else $error("interrupt rose with no acquisition or write");
    a_freeze_hold: assert property (
        !clk_en_i |=> $stable(rd_data_o) && $stable(irq_o))
        else $error("outputs moved while clock enable was low");
endmodule : cell_alert_chk

bind cell_alert_and_minmax_locator cell_alert_chk u_chk (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .acq_i     (acq_i),
    .bus_i     (bus_i),
    .rd_data_o (rd_data_o),
    .irq_o     (irq_o)
);
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the cell alert and extreme locator block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import cell_alert_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        clk_en_i  = 1'b1;
    acq_type     acq_i     = '0;
    bus_req_type bus_i     = '0;
    logic [15:0] rd_data_o;
    logic        irq_o;
    int          failures  = 0;
    int          cmp_count = 0;
    int          seed      = 32'hC402;
    logic [13:0] ov_en, uv_en, cell_en, pol, ov_f, uv_f;
    logic [15:0] th [4];
    logic [15:0] ex, got;
    logic [1:0]  ctrl;
    logic [2:0]  mask, stat;
    acq_type     a_v;

    always #5 sys_clk_i = ~sys_clk_i;

    cell_alert_and_minmax_locator DUT (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .clk_en_i  (clk_en_i),
        .acq_i     (acq_i),
        .bus_i     (bus_i),
        .rd_data_o (rd_data_o),
        .irq_o     (irq_o)
    );

    task automatic chk16(input logic [15:0] exp, input logic [15:0] act);
        cmp_count++;
        if (act !== exp) begin
            failures++;
            $display("BAD time=%0t expected=%h got=%h", $time, exp, act);
        end
    endtask : chk16

    task automatic bus_op(input logic [7:0] a, input logic [15:0] d,
                          input logic w);
        @(posedge sys_clk_i);
        bus_i <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge sys_clk_i);
        bus_i <= '0;
        #1 got = rd_data_o;
    endtask : bus_op

    task automatic acq_op(input logic e, input acq_type a);
        @(posedge sys_clk_i);
        acq_i    <= a;
        clk_en_i <= e;
        @(posedge sys_clk_i);
        acq_i.done <= 1'b0;
        clk_en_i   <= 1'b1;
        #1;
    endtask : acq_op

    // Threshold index is {under, bipolar}, matching the register order.
    function automatic logic [13:0] alert(input acq_type a, input logic uv);
        logic [15:0] t;
        logic        hit;
        alert = '0;
        for (int n = 0; n < NUM_CELLS; n++) begin
            t = th[{uv, pol[n]}];
            if (pol[n])
                hit = uv ? $signed(a.alu[n]) < $signed(t)
                         : $signed(a.alu[n]) > $signed(t);
            else
                hit = uv ? a.alu[n] < t : a.alu[n] > t;
            alert[n] = hit && (uv ? uv_en[n] : ov_en[n]);
        end
    endfunction : alert

    function automatic logic [15:0] extreme(input acq_type a);
        logic signed [16:0] v, hv, lv;
        logic [3:0]         hi, lo;
        hi = NO_RESULT;
        lo = NO_RESULT;
        hv = '0;
        lv = '0;
        for (int n = 0; n < NUM_CELLS; n++) begin
            if (cell_en[n] && pol[n] == ctrl[1]) begin
                v = ctrl[0] ? {1'b0, a.iir[n]} : {1'b0, a.alu[n]};
                if (ctrl[1])
                    v[16] = v[15];
                if (hi == NO_RESULT || v > hv) begin
                    hv = v;
                    hi = 4'(n + 1);
                end
                if (lo == NO_RESULT || v < lv) begin
                    lv = v;
                    lo = 4'(n + 1);
                end
            end
        end
        return {4'h0, hi, 4'h0, lo};
    endfunction : extreme

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    initial begin
        #200000;
        failures++;
        end_of_test();
    end

    initial begin
        ov_f = '0;
        uv_f = '0;
        ex   = '0;
        stat = '0;
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        for (int r = 8; r < 11; r++) begin
            bus_op(8'(r), 16'h0000, 1'b0);
            chk16(READ_ZERO, got);
        end
        bus_op(8'h3F, 16'h0000, 1'b0);
        chk16(READ_ZERO, got);
        for (int i = 0; i < 40; i++) begin
            // Pass 0 leaves the bipolar set empty; pass 10 disables all.
            if (i % 5 == 0) begin
                ov_en   = 14'($random(seed));
                uv_en   = 14'($random(seed));
                cell_en = (i == 10) ? 14'h0000 : 14'($random(seed));
                pol     = (i == 0) ? 14'h0000 : 14'($random(seed));
                ctrl    = (i == 0) ? 2'h2 : 2'($random(seed));
                mask    = 3'($random(seed));
                bus_op(ADDR_OVER_EN, {2'h0, ov_en}, 1'b1);
                bus_op(ADDR_UNDER_EN, {2'h0, uv_en}, 1'b1);
                bus_op(ADDR_CELL_EN, {2'h0, cell_en}, 1'b1);
                bus_op(ADDR_POLARITY, {2'h0, pol}, 1'b1);
                bus_op(ADDR_CONTROL, {14'h0000, ctrl}, 1'b1);
                bus_op(ADDR_IRQ_MASK, {13'h0000, mask}, 1'b1);
                for (int k = 0; k < 4; k++) begin
                    th[k] = 16'($random(seed));
                    bus_op(ADDR_UNI_OVER_TH + 8'(k), th[k], 1'b1);
                end
            end
            a_v.done = 1'b1;
            a_v.scan = (i % 3 != 2);
            for (int n = 0; n < NUM_CELLS; n++) begin
                a_v.alu[n] = (i % 5 == 1 && n > 0) ? a_v.alu[0] : 16'($random(seed));
                a_v.iir[n] = (i % 5 == 1 && n > 0) ? a_v.iir[0] : 16'($random(seed));
            end
            if (i % 5 == 2)
                a_v.alu[3] = th[{1'b0, pol[3]}];
            acq_op(i % 7 != 6, a_v);
            if (i % 7 != 6) begin
                stat[0] = stat[0] | (|(alert(a_v, 1'b0) & ~ov_f));
                stat[1] = stat[1] | (|(alert(a_v, 1'b1) & ~uv_f));
                stat[2] = stat[2] | a_v.scan;
                ov_f = alert(a_v, 1'b0);
                uv_f = alert(a_v, 1'b1);
                if (a_v.scan)
                    ex = extreme(a_v);
            end
            chk16({15'h0000, |(stat & mask)}, {15'h0000, irq_o});
            for (int k = 0; k < 2; k++) begin
                bus_op(ADDR_OVER_FLAGS, 16'h0000, 1'b0);
                chk16({2'h0, ov_f}, got);
                bus_op(ADDR_UNDER_FLAGS, 16'h0000, 1'b0);
                chk16({2'h0, uv_f}, got);
                bus_op(ADDR_EXTREME, 16'h0000, 1'b0);
                chk16(ex, got);
                for (int r = 8; r < 11; r++)
                    bus_op(8'(r), 16'($random(seed)), 1'b1);
            end
            bus_op(ADDR_IRQ_STATUS, 16'h0000, 1'b0);
            chk16({13'h0000, stat}, got);
            stat = 3'h0;
        end
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
